/* hdl/cwg_guard.sv */
`timescale 1ns/1ps
module cwg_guard
   import cwg_pkg::*;
#(
   parameter int NCMD = 256
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // write transaction from protocol engine
   input wire logic WR_START_I,
   input wire logic [7:0] WR_CMD_I,
   input wire logic WR_BYTE_VALID_I,
   input wire logic [7:0] WR_BYTE_I,
   input wire logic WR_END_I,
   // read request
   input wire logic RD_REQ_I,
   input wire logic [7:0] RD_CMD_I,
   input wire logic [7:0] RD_IDX_I,
   // store contents
   input wire logic [NCMD-1:0] DEF_MASK_I,
   input wire logic [NCMD-1:0] USR_MASK_I,
   input wire logic [8*SECRET_LEN-1:0] DEF_SECRET_I,
   input wire logic [8*SECRET_LEN-1:0] USR_SECRET_I,
   input wire logic [8*OPEN_LEN-1:0] USR_OPEN_I,
   input wire logic [8*OPEN_LEN-1:0] DEF_OPEN_I,
   // results
   output logic [7:0] ACCESS_TIER_O,
   output logic WR_ALLOW_O,
   output logic WR_COMMIT_O,
   output logic WR_REFUSE_O,
   output logic [7:0] WR_CMD_O,
   output logic [7:0] RD_DATA_O,
   output logic RD_VALID_O
);

////////////////////////////////////////////////////////////////////////////
   cwg_state_t state;
   logic [7:0] tier;
   logic [7:0] next_tier;
   logic [7:0] cmd;
   logic allow;
   logic [3:0] cnt;
   logic [8*SECRET_LEN-1:0] secret_buf;
   logic [8*OPEN_LEN-1:0] open_buf;
   logic [8*SECRET_LEN-1:0] secret_last;
   logic [8*OPEN_LEN-1:0] open_last;
   logic in_data;
   logic take_byte;
   logic wr_done;
   logic secret_len_ok;
   logic open_len_ok;
   logic secret_ok;
   logic open_ok;

   // lowest tier that may write a command, from the two masks
   function automatic logic [7:0] needed_tier(input logic [7:0] c);
      logic [7:0] n;
      n = TIER_OPEN;
      if (!DEF_MASK_I[c])
         n = TIER_VENDOR;
      else if (!USR_MASK_I[c])
         n = TIER_USER;
      else
         n = TIER_OPEN;
      return n;
   endfunction : needed_tier

   // permit decision for a command at a tier
   function automatic logic permit(input logic [7:0] c, input logic [7:0] t);
      logic p;
      p = 1'b0;
      if (c == CMD_OPEN_PW)
         p = 1'b1;
      else if (c == CMD_ACCESS_TIER)
         p = 1'b0;
      else
         p = (t >= needed_tier(c));
      return p;
   endfunction : permit

   // secret password byte, zero past the end of the block
   function automatic logic [7:0] secret_byte(input logic [7:0] i);
      logic [7:0] b;
      b = BYTE_ZERO;
      if (i < 8'(SECRET_LEN))
         b = secret_last[8*i +: 8];
      return b;
   endfunction : secret_byte

   // open password byte, zero past the end of the block
   function automatic logic [7:0] open_byte(input logic [7:0] i);
      logic [7:0] b;
      b = BYTE_ZERO;
      if (i < 8'(OPEN_LEN))
         b = open_last[8*i +: 8];
      return b;
   endfunction : open_byte

   // read mux; tier and both passwords are readable whatever the tier, other commands read zero
   function automatic logic [7:0] read_byte(input logic [7:0] c,
      input logic [7:0] i);
      logic [7:0] d;
      d = BYTE_ZERO;
      unique case (c)
         CMD_ACCESS_TIER: d = tier;
         CMD_SECRET_PW: d = secret_byte(i);
         CMD_OPEN_PW: d = open_byte(i);
         default: d = BYTE_ZERO;
      endcase
      return d;
   endfunction : read_byte

////////////////////////////////////////////////////////////////////////////
   // strobes of the write transaction; a new start wins over data and end
   assign in_data = (state == CWG_DATA);
   assign take_byte = in_data && WR_BYTE_VALID_I && !WR_START_I;
   assign wr_done = in_data && WR_END_I && !WR_START_I;

   // transaction state
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         state <= CWG_IDLE;
      else if (WR_START_I)
         state <= CWG_DATA;
      else if (wr_done)
         state <= CWG_IDLE;
   end

   // command of the write in progress
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         cmd <= BYTE_ZERO;
      else if (WR_START_I)
         cmd <= WR_CMD_I;
   end

   // byte count saturates, so an overlong block can never wrap to a match
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         cnt <= '0;
      else if (WR_START_I)
         cnt <= '0;
      else if (take_byte && cnt != '1)
         cnt <= cnt + 4'h1;
   end

   // secret block, first byte ends up in the low bits
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         secret_buf <= '0;
      else if (WR_START_I)
         secret_buf <= '0;
      else if (take_byte && cnt < 4'(SECRET_LEN))
         secret_buf <= {WR_BYTE_I, secret_buf[8*SECRET_LEN-1:8]};
   end

   // open block, first byte ends up in the low bits
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         open_buf <= '0;
      else if (WR_START_I)
         open_buf <= '0;
      else if (take_byte && cnt < 4'(OPEN_LEN))
         open_buf <= {WR_BYTE_I, open_buf[8*OPEN_LEN-1:8]};
   end

   // full-length compares; short or long blocks never match
   assign secret_len_ok = (cnt == 4'(SECRET_LEN));
   assign open_len_ok = (cnt == 4'(OPEN_LEN));
   // a refused secret write never raises the tier
   assign secret_ok = secret_len_ok && allow;
   assign open_ok = open_len_ok && (open_buf == USR_OPEN_I);

   // permission captured at start, reported as a level
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         allow <= 1'b0;
      else if (WR_START_I)
         allow <= permit(WR_CMD_I, tier);
   end

////////////////////////////////////////////////////////////////////////////
   // tier after a finished password write
   always_comb begin
      next_tier = tier;
      if (wr_done && cmd == CMD_OPEN_PW)
         next_tier = open_ok ? TIER_OPEN : TIER_LOCKED;
      else if (wr_done && cmd == CMD_SECRET_PW && secret_ok) begin
         if (secret_buf == DEF_SECRET_I)
            next_tier = TIER_VENDOR;
         else if (secret_buf == USR_SECRET_I)
            next_tier = TIER_USER;
      end // mismatch keeps tier
   end

   // access tier
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         tier <= TIER_RESET;
      else
         tier <= next_tier;
   end

   // last accepted secret password, readable back
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         secret_last <= '0;
      else if (wr_done && cmd == CMD_SECRET_PW && secret_ok)
         secret_last <= secret_buf;
   end

   // last full-length open password, readable back
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         open_last <= '0;
      else if (wr_done && cmd == CMD_OPEN_PW && open_len_ok)
         open_last <= open_buf;
   end

////////////////////////////////////////////////////////////////////////////
   // permit of the current write, held until the next start
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         WR_ALLOW_O <= 1'b0;
      else
         WR_ALLOW_O <= allow;
   end

   // registered tier for the outside world
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         ACCESS_TIER_O <= TIER_RESET;
      else
         ACCESS_TIER_O <= tier;
   end

   // accepted write, one-cycle pulse
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         WR_COMMIT_O <= 1'b0;
      else
         WR_COMMIT_O <= wr_done && allow;
   end

   // refused write, data discarded, one-cycle pulse
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         WR_REFUSE_O <= 1'b0;
      else
         WR_REFUSE_O <= wr_done && !allow;
   end

   // command of the last finished write
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         WR_CMD_O <= BYTE_ZERO;
      else if (wr_done)
         WR_CMD_O <= cmd;
   end

   // read strobe, one cycle after the request
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         RD_VALID_O <= 1'b0;
      else
         RD_VALID_O <= RD_REQ_I;
   end

   // reads are never gated
   always_ff @(posedge CLOCK_I) begin
      if (RST_I)
         RD_DATA_O <= BYTE_ZERO;
      else if (RD_REQ_I)
         RD_DATA_O <= read_byte(RD_CMD_I, RD_IDX_I);
      else
         RD_DATA_O <= BYTE_ZERO;
   end

endmodule : cwg_guard

/* hdl/cwg_pkg.sv */
package cwg_pkg;
   // command codes seen by the guard
   localparam logic [7:0] CMD_ACCESS_TIER = 8'hfa;
   localparam logic [7:0] CMD_SECRET_PW = 8'hfb;
   localparam logic [7:0] CMD_OPEN_PW = 8'hfc;
   // password lengths in bytes
   localparam int SECRET_LEN = 9;
   localparam int OPEN_LEN = 4;
   // access tiers
   localparam logic [7:0] TIER_LOCKED = 8'h00;
   localparam logic [7:0] TIER_OPEN = 8'h01;
   localparam logic [7:0] TIER_USER = 8'h02;
   localparam logic [7:0] TIER_VENDOR = 8'h03;
   localparam logic [7:0] TIER_RESET = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   typedef enum {CWG_IDLE, CWG_CMD, CWG_DATA} cwg_state_t;
endpackage : cwg_pkg

/* verification/cwg_guard_asserts.sv */
`timescale 1ns/1ps
module cwg_guard_asserts
   import cwg_pkg::*;
(
   // watched ports
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic WR_END_I,
   input wire logic [7:0] ACCESS_TIER_O,
   input wire logic WR_COMMIT_O,
   input wire logic WR_REFUSE_O,
   input wire logic [7:0] WR_CMD_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   sequence s_answer;
      WR_COMMIT_O || WR_REFUSE_O;
   endsequence
   a_end_answer: assert property (WR_END_I |=> s_answer)
      else $error("no answer to write");
   a_reset_tier: assert property ($past(RST_I) |-> ACCESS_TIER_O == 8'h01)
      else $error("bad tier after reset");
   a_tier_cause: assert property ($changed(ACCESS_TIER_O) |-> $past(WR_COMMIT_O))
      else $error("tier moved without write");
   a_one_answer: assert property (!(WR_COMMIT_O && WR_REFUSE_O))
      else $error("write both taken and refused");
   a_tier_ro: assert property (WR_COMMIT_O |-> WR_CMD_O != CMD_ACCESS_TIER)
      else $error("tier register written");
   a_tier_range: assert property (ACCESS_TIER_O <= TIER_VENDOR)
      else $error("tier out of range");
   a_locked_open: assert property (WR_COMMIT_O && ACCESS_TIER_O == TIER_LOCKED
      |-> WR_CMD_O == CMD_OPEN_PW)
      else $error("locked tier took write");
   a_commit_pulse: assert property (WR_COMMIT_O |=> !WR_COMMIT_O)
      else $error("commit longer than a cycle");
endmodule : cwg_guard_asserts
bind cwg_guard cwg_guard_asserts u_asserts (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
   .WR_END_I(WR_END_I), .ACCESS_TIER_O(ACCESS_TIER_O),
   .WR_COMMIT_O(WR_COMMIT_O), .WR_REFUSE_O(WR_REFUSE_O), .WR_CMD_O(WR_CMD_O));

/* verification/cwg_host.sv */
`timescale 1ns/1ps
module cwg_host (
   // clock
   input wire logic clock_i,
   // write transfer
   output logic wr_start_o = 1'b0,
   output logic [7:0] wr_cmd_o = 8'h00,
   output logic wr_byte_valid_o = 1'b0,
   output logic [7:0] wr_byte_o = 8'h00,
   output logic wr_end_o = 1'b0,
   input wire logic [1:0] wr_ans_i,
   // read transfer
   output logic rd_req_o = 1'b0,
   output logic [7:0] rd_cmd_o = 8'h00,
   output logic [7:0] rd_idx_o = 8'h00,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i
);
   // bytes go out byte0 first, end one cycle after the last byte
   task automatic wr(input logic [7:0] c, input logic [71:0] d, input int n,
      output logic [1:0] a);
      @(posedge clock_i) #1;
      wr_cmd_o = c;
      wr_start_o = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge clock_i) #1;
         wr_start_o = 1'b0;
         wr_byte_o = d[8*i+:8];
         wr_byte_valid_o = 1'b1;
      end
      @(posedge clock_i) #1;
      wr_byte_valid_o = 1'b0;
      wr_byte_o = ~wr_byte_o;
      wr_end_o = 1'b1;
      @(posedge clock_i) #1;
      wr_end_o = 1'b0;
      a = wr_ans_i;
      @(posedge clock_i) #1;
   endtask : wr
   task automatic rd(input logic [7:0] c, input logic [7:0] x,
      output logic [7:0] q);
      @(posedge clock_i) #1;
      rd_cmd_o = c;
      rd_idx_o = x;
      rd_req_o = 1'b1;
      @(posedge clock_i) #1;
      rd_req_o = 1'b0;
      q = rd_valid_i ? rd_data_i : 8'hxx;
   endtask : rd
endmodule : cwg_host

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import cwg_pkg::*;
   localparam logic [71:0] USR_PW = 72'h99_8877_6655_4433_2211;
   localparam logic [71:0] DEF_PW = 72'h19_2837_4655_6473_8291;
   logic clk = 1'b0, rst = 1'b1;
   logic ws, wv, we, rr, rv;
   wire [1:0] ans;
   logic [1:0] a;
   logic wa;
   logic [7:0] wc, wb, rc, ri, rdat, tier, q;
   // store setup clears permit bits the way the configurer would
   logic [255:0] dm = {{222{1'b1}}, 1'b0, {33{1'b1}}}, um = '1;
   logic [31:0] uo = 32'h6e65_706f, dp = 32'h0bad_cafe;
   int failures = 0, comparisons = 0;
   always #10 clk = ~clk;
   cwg_host host (.clock_i(clk), .wr_start_o(ws), .wr_cmd_o(wc),
      .wr_byte_valid_o(wv), .wr_byte_o(wb), .wr_end_o(we), .wr_ans_i(ans),
      .rd_req_o(rr), .rd_cmd_o(rc), .rd_idx_o(ri), .rd_valid_i(rv),
      .rd_data_i(rdat));
   cwg_guard dut (.CLOCK_I(clk), .RST_I(rst), .WR_START_I(ws), .WR_CMD_I(wc),
      .WR_BYTE_VALID_I(wv), .WR_BYTE_I(wb), .WR_END_I(we), .RD_REQ_I(rr),
      .RD_CMD_I(rc), .RD_IDX_I(ri), .DEF_MASK_I(dm), .USR_MASK_I(um),
      .DEF_SECRET_I(DEF_PW), .USR_SECRET_I(USR_PW), .USR_OPEN_I(uo),
      .DEF_OPEN_I(dp), .ACCESS_TIER_O(tier), .WR_ALLOW_O(wa),
      .WR_COMMIT_O(ans[1]), .WR_REFUSE_O(ans[0]), .WR_CMD_O(),
      .RD_DATA_O(rdat), .RD_VALID_O(rv));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // expected answer: 02 taken, 01 refused
   task automatic w(input logic [7:0] c, input logic [71:0] d, input int n,
      input logic [7:0] e);
      host.wr(c, d, n, a);
      chk({6'h00, a}, e);
      chk({7'h00, wa}, {7'h00, e[1]});
   endtask : w
   task automatic complete_run;
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      chk(tier, TIER_RESET);
      host.rd(CMD_ACCESS_TIER, 8'h00, q);
      chk(q, TIER_OPEN);
      w(8'h10, 72'h5a, 1, 8'h02);
      w(8'h21, 72'h5a, 1, 8'h01);
      w(CMD_ACCESS_TIER, 72'h03, 1, 8'h01);
      host.wr(CMD_SECRET_PW, USR_PW ^ {8'h01, 64'h0}, SECRET_LEN, a);
      chk(tier, TIER_OPEN);
      um[32] = 1'b0;
      w(8'h20, 72'h5a, 1, 8'h01);
      w(CMD_SECRET_PW, USR_PW, SECRET_LEN, 8'h02);
      chk(tier, TIER_USER);
      w(8'h20, 72'h5a, 1, 8'h02);
      w(8'h21, 72'h5a, 1, 8'h01);
      w(CMD_SECRET_PW, DEF_PW, SECRET_LEN, 8'h02);
      chk(tier, TIER_VENDOR);
      w(8'h21, 72'h5a, 1, 8'h02);
      w(CMD_OPEN_PW, {40'h0, dp}, OPEN_LEN, 8'h02);
      chk(tier, TIER_LOCKED);
      w(8'h10, 72'h5a, 1, 8'h01);
      host.rd(CMD_OPEN_PW, 8'h00, q);
      chk(q, 8'hfe);
      w(CMD_OPEN_PW, {40'h0, uo}, OPEN_LEN, 8'h02);
      chk(tier, TIER_OPEN);
      w(CMD_SECRET_PW, 72'h0, SECRET_LEN, 8'h02);
      chk(tier, TIER_OPEN);
      complete_run();
   end
   initial begin
      #100000;
      failures++;
      complete_run();
   end
endmodule : tb_top
